// *** emr_register_bank.sv ***
// Register bank of the single-phase energy meter: results, calibration and configuration.
`timescale 1ns/100ps

// Operation
// R1 - Writing the soft reset key returns all host registers to defaults.
// R2 - Host registers are writable only while the protect register holds the key; the code keeps the protect register itself writable at any time.
// R3 - Fast current RMS is a 24-bit unsigned read-only result.
// R4 - Current and voltage waveform samples are 20-bit signed read-only registers.
// R5 - Current and voltage RMS are 24-bit unsigned read-only results.
// R6 - Active power is a 24-bit signed read-only result.
// R7 - A 24-bit read-only counter counts emitted energy pulses.
// R8 - Internal and external temperatures are 10-bit unsigned read-only registers.
// R9 - Phase angle is a 16-bit read-only result.
// R10 - Fast RMS is refreshed over a full or half mains cycle window.
// R11 - Zero-cross output changes a fixed delay after the voltage zero crossing.
// R12 - No-load threshold powers up nonzero so anti-creep works unconfigured.
// R13 - Fast RMS control is host read/write, read internally, resets to all ones.
// R14 - Three 8-bit offset trims are host writable, reset to zero, used internally.
// R15 - A mode bit selects RMS refresh period of 400 ms or 800 ms.
// R16 - External temperature alarm when reading is at least the 10-bit threshold.
// R17 - Host writes to measurement result registers are ignored.
module emr_register_bank #(
	parameter int FAST_FULL_CYCLES = emr_pkg::FAST_FULL_CYC,
	parameter int FAST_HALF_CYCLES = emr_pkg::FAST_HALF_CYC,
	parameter int ZX_DELAY_CYCLES = emr_pkg::ZX_DELAY_CYC,
	parameter int RMS_FAST_CYCLES = emr_pkg::RMS_FAST_CYC,
	parameter int RMS_SLOW_CYCLES = emr_pkg::RMS_SLOW_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] host_addr,
	input wire logic [23:0] host_wdata,
	input wire logic host_wr,
	input wire logic host_rd,
	output logic [23:0] host_rdata,
	output logic host_rvalid,
	input wire logic [23:0] dsp_fast_rms,
	input wire logic [19:0] dsp_i_wave,
	input wire logic [19:0] dsp_v_wave,
	input wire logic dsp_wave_valid,
	input wire logic [23:0] dsp_i_rms,
	input wire logic [23:0] dsp_voltage_rms_result,
	input wire logic [23:0] dsp_power,
	input wire logic [15:0] dsp_phase,
	input wire logic dsp_energy_pulse,
	input wire logic [9:0] dsp_int_temp,
	input wire logic [9:0] dsp_ext_temp,
	input wire logic dsp_temp_valid,
	output logic [15:0] fast_rms_control,
	output logic [7:0] current_dc_offset_trim,
	output logic [7:0] current_rms_offset_trim,
	output logic [7:0] power_offset_trim,
	output logic [7:0] no_load_threshold,
	output logic [15:0] user_mode_select,
	output logic [15:0] temperature_control,
	output logic [7:0] ext_temp_gain_trim,
	output logic [7:0] ext_temp_offset_trim,
	output logic zero_cross_output,
	output logic energy_pulse_output,
	output logic ext_temp_alarm
);
	import emr_pkg::*;

	logic [23:0] fast_rms_r, i_rms_r, voltage_rms_result_r, power_r, pulse_cnt_r, soft_r;
	logic [19:0] i_wave_r, v_wave_r;
	logic [15:0] phase_r;
	logic [9:0] int_temp_r, ext_temp_r;
	logic [7:0] wprot_r;
	logic [31:0] fast_cnt_r, rms_cnt_r, zx_cnt_r;
	logic zx_pend_r, v_sign_r, zx_target_r;

	// Host register write decode.
	wire unlocked = (wprot_r == WRITE_ENABLE_KEY); // R2
	wire soft_reset = host_wr && unlocked && (host_addr == ADDR_SOFT_RST)
		&& (host_wdata == SOFT_RESET_KEY); // R1
	wire cfg_wr = host_wr && unlocked && !soft_reset; // R2
	wire wr_wprot = host_wr && (host_addr == ADDR_WPROT);
	wire [7:0] wd8 = host_wdata[7:0];
	wire [15:0] wd16 = host_wdata[15:0];

	// Refresh windows.
	wire [31:0] fast_len = fast_rms_control[FAST_HALF_BIT] ?
		32'(FAST_HALF_CYCLES) : 32'(FAST_FULL_CYCLES); // R10
	wire [31:0] rms_len = user_mode_select[MODE_RMS_SEL_BIT] ?
		32'(RMS_SLOW_CYCLES) : 32'(RMS_FAST_CYCLES); // R15
	wire fast_tick = (fast_cnt_r >= fast_len - 32'd1);
	wire rms_tick = (rms_cnt_r >= rms_len - 32'd1);
	wire v_sign = dsp_v_wave[19];
	wire zx_event = dsp_wave_valid && (v_sign != v_sign_r);
	wire zx_done = zx_pend_r && (zx_cnt_r >= 32'(ZX_DELAY_CYCLES) - 32'd1);
	wire [9:0] temp_thr = temperature_control[TEMP_THR_MSB:0];

	// Waveform samples read back sign-extended to the full bus width.
	function automatic logic [23:0] sext20(input logic [19:0] s);
		return {{4{s[19]}}, s};
	endfunction

	// Read mux; unmapped addresses and result gaps read as zero.
	logic [23:0] rd_mux;
	always_comb begin
		case (host_addr)
			ADDR_FAST_RMS: rd_mux = fast_rms_r;
			ADDR_I_WAVE: rd_mux = sext20(i_wave_r);
			ADDR_V_WAVE: rd_mux = sext20(v_wave_r);
			ADDR_I_RMS: rd_mux = i_rms_r;
			ADDR_VOLTAGE_RMS_RESULT: rd_mux = voltage_rms_result_r;
			ADDR_POWER: rd_mux = power_r;
			ADDR_PULSE_CNT: rd_mux = pulse_cnt_r;
			ADDR_PHASE: rd_mux = {8'h00, phase_r};
			ADDR_INT_TEMP: rd_mux = {14'h0000, int_temp_r};
			ADDR_EXT_TEMP: rd_mux = {14'h0000, ext_temp_r};
			ADDR_FAST_CTRL: rd_mux = {8'h00, fast_rms_control};
			ADDR_DC_TRIM: rd_mux = {16'h0000, current_dc_offset_trim};
			ADDR_RMS_TRIM: rd_mux = {16'h0000, current_rms_offset_trim};
			ADDR_PWR_TRIM: rd_mux = {16'h0000, power_offset_trim};
			ADDR_CREEP: rd_mux = {16'h0000, no_load_threshold};
			ADDR_MODE: rd_mux = {8'h00, user_mode_select};
			ADDR_SOFT_RST: rd_mux = soft_r;
			ADDR_WPROT: rd_mux = {16'h0000, wprot_r};
			ADDR_TEMP_CTRL: rd_mux = {8'h00, temperature_control};
			ADDR_TGAIN: rd_mux = {16'h0000, ext_temp_gain_trim};
			ADDR_TOFFS: rd_mux = {16'h0000, ext_temp_offset_trim};
			default: rd_mux = 24'h00_0000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			host_rdata <= 24'h00_0000;
			host_rvalid <= 1'b0;
		end else begin
			host_rvalid <= host_rd;
			if (host_rd) begin
				host_rdata <= rd_mux;
			end
		end
	end

	// Host-operated configuration registers.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fast_rms_control <= RST_FAST_CTRL;
			current_dc_offset_trim <= RST_TRIM;
			current_rms_offset_trim <= RST_TRIM;
			power_offset_trim <= RST_TRIM;
			no_load_threshold <= RST_CREEP;
			user_mode_select <= RST_MODE;
			soft_r <= RST_SOFT;
			temperature_control <= RST_TEMP_CTRL;
			ext_temp_gain_trim <= RST_TRIM;
			ext_temp_offset_trim <= RST_TRIM;
		end else if (soft_reset) begin // R1
			fast_rms_control <= RST_FAST_CTRL; // R13
			current_dc_offset_trim <= RST_TRIM; // R14
			current_rms_offset_trim <= RST_TRIM;
			power_offset_trim <= RST_TRIM;
			no_load_threshold <= RST_CREEP; // R12
			user_mode_select <= RST_MODE;
			soft_r <= RST_SOFT;
			temperature_control <= RST_TEMP_CTRL;
			ext_temp_gain_trim <= RST_TRIM;
			ext_temp_offset_trim <= RST_TRIM;
		end else if (cfg_wr) begin // R2
			case (host_addr)
				ADDR_FAST_CTRL: fast_rms_control <= wd16; // R13
				ADDR_DC_TRIM: current_dc_offset_trim <= wd8; // R14
				ADDR_RMS_TRIM: current_rms_offset_trim <= wd8; // R14
				ADDR_PWR_TRIM: power_offset_trim <= wd8; // R14
				ADDR_CREEP: no_load_threshold <= wd8;
				ADDR_MODE: user_mode_select <= wd16;
				ADDR_SOFT_RST: soft_r <= host_wdata;
				ADDR_TEMP_CTRL: temperature_control <= wd16;
				ADDR_TGAIN: ext_temp_gain_trim <= wd8;
				ADDR_TOFFS: ext_temp_offset_trim <= wd8;
				default: soft_r <= soft_r; // R17
			endcase
		end
	end

	// The protect register stays writable so the host can unlock the bank.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wprot_r <= RST_WPROT;
		end else if (soft_reset) begin
			wprot_r <= RST_WPROT; // R1
		end else if (wr_wprot) begin
			wprot_r <= wd8; // R2
		end
	end

	// Measurement results, written only by internal logic.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			i_wave_r <= 20'h0_0000;
			v_wave_r <= 20'h0_0000;
			int_temp_r <= 10'h000;
			ext_temp_r <= 10'h000;
			pulse_cnt_r <= 24'h00_0000;
			energy_pulse_output <= 1'b0;
		end else begin
			if (dsp_wave_valid) begin
				i_wave_r <= dsp_i_wave; // R4
				v_wave_r <= dsp_v_wave; // R4
			end
			if (dsp_temp_valid) begin
				int_temp_r <= dsp_int_temp; // R8
				ext_temp_r <= dsp_ext_temp; // R8
			end
			if (dsp_energy_pulse) begin
				pulse_cnt_r <= pulse_cnt_r + 24'h00_0001; // R7
			end
			energy_pulse_output <= dsp_energy_pulse;
		end
	end

	// Fast RMS window and slow RMS refresh period.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fast_cnt_r <= 32'h0000_0000;
			rms_cnt_r <= 32'h0000_0000;
			fast_rms_r <= 24'h00_0000;
			i_rms_r <= 24'h00_0000;
			voltage_rms_result_r <= 24'h00_0000;
			power_r <= 24'h00_0000;
			phase_r <= 16'h0000;
		end else begin
			fast_cnt_r <= fast_tick ? 32'h0000_0000 : fast_cnt_r + 32'd1;
			rms_cnt_r <= rms_tick ? 32'h0000_0000 : rms_cnt_r + 32'd1;
			if (fast_tick) begin
				fast_rms_r <= dsp_fast_rms; // R3 R10
			end
			if (rms_tick) begin
				i_rms_r <= dsp_i_rms; // R5 R15
				voltage_rms_result_r <= dsp_voltage_rms_result; // R5
				power_r <= dsp_power; // R6
				phase_r <= dsp_phase; // R9
			end
		end
	end

	// Zero crossing: a sign change of the voltage sample starts the delay.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			v_sign_r <= 1'b0;
			zx_pend_r <= 1'b0;
			zx_target_r <= 1'b0;
			zx_cnt_r <= 32'h0000_0000;
			zero_cross_output <= 1'b0;
		end else begin
			if (dsp_wave_valid) begin
				v_sign_r <= v_sign;
			end
			if (zx_event) begin
				zx_pend_r <= 1'b1;
				zx_target_r <= ~v_sign;
				zx_cnt_r <= 32'h0000_0000;
			end else if (zx_done) begin
				zx_pend_r <= 1'b0;
				zero_cross_output <= zx_target_r; // R11
			end else if (zx_pend_r) begin
				zx_cnt_r <= zx_cnt_r + 32'd1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ext_temp_alarm <= 1'b0;
		end else begin
			ext_temp_alarm <= (ext_temp_r >= temp_thr); // R16
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	locked_write_a: assert property ( // R2
		(host_wr && !unlocked && host_addr == ADDR_MODE) |=> $stable(user_mode_select))
		else $error("Mode register changed while write protected");
	soft_reset_a: assert property ( // R1
		soft_reset |=> (fast_rms_control == RST_FAST_CTRL && no_load_threshold == RST_CREEP
		&& temperature_control == RST_TEMP_CTRL && wprot_r == RST_WPROT))
		else $error("Soft reset key did not restore defaults");
	unlocked_write_a: assert property ( // R14
		(cfg_wr && host_addr == ADDR_PWR_TRIM) |=> power_offset_trim == $past(wd8))
		else $error("Unlocked trim write not stored");
	result_ro_a: assert property ( // R17
		(host_wr && host_addr == ADDR_I_RMS && !rms_tick) |=> $stable(i_rms_r))
		else $error("Host write altered a result register");
	pulse_count_a: assert property ( // R7
		dsp_energy_pulse |=> pulse_cnt_r == $past(pulse_cnt_r) + 24'h00_0001)
		else $error("Energy pulse not counted");
	wave_sign_a: assert property ( // R4
		(host_rd && host_addr == ADDR_I_WAVE) |=> host_rvalid && host_rdata[23:19] == {5{i_wave_r[19]}})
		else $error("Waveform read not sign extended");
	zx_delay_a: assert property ( // R11
		$changed(zero_cross_output) |-> $past(zx_pend_r) && $past(zx_cnt_r) == 32'(ZX_DELAY_CYCLES) - 32'd1)
		else $error("Zero-cross output moved at wrong delay");
	temp_alarm_a: assert property ( // R16
		(ext_temp_r >= temp_thr) |=> ext_temp_alarm)
		else $error("External temperature alarm missing");
	rms_period_a: assert property ( // R15
		rms_tick |-> rms_cnt_r == rms_len - 32'd1)
		else $error("RMS refresh at wrong period");
	fast_window_a: assert property ( // R10
		fast_tick |-> fast_cnt_r == fast_len - 32'd1)
		else $error("Fast RMS window ended at wrong count");

	// Results follow their sources one cycle after the strobe that takes them.
	fast_result_a: assert property ( // R3
		fast_tick |=> fast_rms_r == $past(dsp_fast_rms))
		else $error("Fast RMS result not taken at window end");
	rms_result_a: assert property ( // R5
		rms_tick |=> i_rms_r == $past(dsp_i_rms) && voltage_rms_result_r == $past(dsp_voltage_rms_result))
		else $error("RMS results not taken at refresh");
	power_phase_a: assert property ( // R6 R9
		rms_tick |=> power_r == $past(dsp_power) && phase_r == $past(dsp_phase))
		else $error("Power or phase result not taken at refresh");
	wave_store_a: assert property ( // R4
		dsp_wave_valid |=> i_wave_r == $past(dsp_i_wave) && v_wave_r == $past(dsp_v_wave))
		else $error("Waveform samples not stored");
	temp_store_a: assert property ( // R8
		dsp_temp_valid |=> int_temp_r == $past(dsp_int_temp)
		&& ext_temp_r == $past(dsp_ext_temp))
		else $error("Temperature readings not stored");
	trim_reset_a: assert property ( // R14
		soft_reset |=> current_dc_offset_trim == RST_TRIM
		&& current_rms_offset_trim == RST_TRIM && power_offset_trim == RST_TRIM)
		else $error("Offset trims not cleared by soft reset");
	fast_ctrl_a: assert property ( // R13
		(cfg_wr && host_addr == ADDR_FAST_CTRL) |=> fast_rms_control == $past(wd16))
		else $error("Fast RMS control write not stored");
	wprot_open_a: assert property ( // R2
		wr_wprot |=> wprot_r == $past(wd8))
		else $error("Protect register write not stored");
	energy_out_a: assert property ( // R7
		dsp_energy_pulse |=> energy_pulse_output)
		else $error("Energy pulse output missing");
	alarm_clear_a: assert property ( // R16
		(ext_temp_r < temp_thr) |=> !ext_temp_alarm)
		else $error("External temperature alarm raised below threshold");

	unlock_write_c: cover property (wr_wprot ##1 cfg_wr);
	soft_reset_c: cover property (soft_reset);
	zx_toggle_c: cover property (zx_done ##1 $changed(zero_cross_output));
	alarm_c: cover property ($rose(ext_temp_alarm));
	slow_refresh_c: cover property (rms_tick && user_mode_select[MODE_RMS_SEL_BIT]);
endmodule

// *** emr_pkg.sv ***
// Address map, reset values, keys and timing constants of the energy meter register bank.
package emr_pkg;
	localparam logic [7:0] ADDR_FAST_RMS = 8'h00;
	localparam logic [7:0] ADDR_I_WAVE = 8'h01;
	localparam logic [7:0] ADDR_V_WAVE = 8'h03;
	localparam logic [7:0] ADDR_I_RMS = 8'h04;
	localparam logic [7:0] ADDR_VOLTAGE_RMS_RESULT = 8'h06;
	localparam logic [7:0] ADDR_POWER = 8'h08;
	localparam logic [7:0] ADDR_PULSE_CNT = 8'h0A;
	localparam logic [7:0] ADDR_PHASE = 8'h0C;
	localparam logic [7:0] ADDR_INT_TEMP = 8'h0E;
	localparam logic [7:0] ADDR_EXT_TEMP = 8'h0F;
	localparam logic [7:0] ADDR_FAST_CTRL = 8'h10;
	localparam logic [7:0] ADDR_DC_TRIM = 8'h11;
	localparam logic [7:0] ADDR_RMS_TRIM = 8'h13;
	localparam logic [7:0] ADDR_PWR_TRIM = 8'h15;
	localparam logic [7:0] ADDR_CREEP = 8'h17;
	localparam logic [7:0] ADDR_MODE = 8'h18;
	localparam logic [7:0] ADDR_SOFT_RST = 8'h19;
	localparam logic [7:0] ADDR_WPROT = 8'h1A;
	localparam logic [7:0] ADDR_TEMP_CTRL = 8'h1B;
	localparam logic [7:0] ADDR_TGAIN = 8'h1C;
	localparam logic [7:0] ADDR_TOFFS = 8'h1D;

	localparam logic [15:0] RST_FAST_CTRL = 16'hFFFF;
	localparam logic [7:0] RST_TRIM = 8'h00;
	localparam logic [7:0] RST_CREEP = 8'h0B;
	localparam logic [15:0] RST_MODE = 16'h0000;
	localparam logic [23:0] RST_SOFT = 24'h00_0000;
	localparam logic [7:0] RST_WPROT = 8'h00;
	localparam logic [15:0] RST_TEMP_CTRL = 16'h07FF;

	localparam logic [23:0] SOFT_RESET_KEY = 24'h5A_5A5A;
	localparam logic [7:0] WRITE_ENABLE_KEY = 8'h55;

	localparam int MODE_RMS_SEL_BIT = 8;
	localparam int FAST_HALF_BIT = 15;
	localparam int TEMP_THR_MSB = 9;

	localparam int CLK_MHZ = 200;
	localparam int FAST_FULL_US = 20000;
	localparam int FAST_HALF_US = 10000;
	localparam int ZX_DELAY_US = 571;
	localparam int RMS_SLOW_MS = 800;
	localparam int RMS_FAST_MS = 400;
	localparam int FAST_FULL_CYC = FAST_FULL_US * CLK_MHZ;
	localparam int FAST_HALF_CYC = FAST_HALF_US * CLK_MHZ;
	localparam int ZX_DELAY_CYC = ZX_DELAY_US * CLK_MHZ;
	localparam int RMS_FAST_CYC = RMS_FAST_MS * 1000 * CLK_MHZ;
	localparam int RMS_SLOW_CYC = RMS_SLOW_MS * 1000 * CLK_MHZ;
endpackage

// *** emr_host_model.sv ***
// Host controller model that issues register writes and reads to the bank.
`timescale 1ns/100ps
module emr_host_model (
	input wire logic sys_clk,
	output logic [7:0] host_addr,
	output logic [23:0] host_wdata,
	output logic host_wr,
	output logic host_rd,
	input wire logic [23:0] host_rdata,
	input wire logic host_rvalid
);
	initial begin
		host_addr = 8'h00;
		host_wdata = 24'h00_0000;
		host_wr = 1'b0;
		host_rd = 1'b0;
	end
	// Released lines show the inverse of their last value so stale data never looks valid.
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(negedge sys_clk);
		host_addr = a;
		host_wdata = d;
		host_wr = 1'b1;
		@(negedge sys_clk);
		host_wr = 1'b0;
		host_addr = ~a;
		host_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [23:0] d);
		int n;
		@(negedge sys_clk);
		host_addr = a;
		host_rd = 1'b1;
		@(negedge sys_clk);
		host_rd = 1'b0;
		host_addr = ~a;
		n = 0;
		while (host_rvalid !== 1'b1 && n < 4) begin
			@(negedge sys_clk);
			n++;
		end
		d = (host_rvalid === 1'b1) ? host_rdata : 24'hxx_xxxx;
	endtask
endmodule

// *** energy_meter_register_map_tb.sv ***
// Self-checking testbench of the energy meter register bank.
`timescale 1ns/100ps
module energy_meter_register_map_tb;
	import emr_pkg::*;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] host_addr;
	logic [23:0] host_wdata, host_rdata, rv;
	logic host_wr, host_rd, host_rvalid;
	logic [23:0] dsp_fast_rms = 24'h00_0000, dsp_i_rms = 24'h00_0000;
	logic [23:0] dsp_voltage_rms_result = 24'h00_0000, dsp_power = 24'h00_0000;
	logic [19:0] dsp_i_wave = 20'h0_0000, dsp_v_wave = 20'h0_0000;
	logic [15:0] dsp_phase = 16'h0000;
	logic [9:0] dsp_int_temp = 10'h000, dsp_ext_temp = 10'h000;
	logic dsp_wave_valid = 1'b0, dsp_energy_pulse = 1'b0, dsp_temp_valid = 1'b0;
	logic [15:0] fast_rms_control, user_mode_select, temperature_control;
	logic [7:0] current_dc_offset_trim, current_rms_offset_trim, power_offset_trim;
	logic [7:0] no_load_threshold, ext_temp_gain_trim, ext_temp_offset_trim;
	logic zero_cross_output, energy_pulse_output, ext_temp_alarm;
	int num_errors = 0;
	int checks = 0;
	int cycles = 0;
	localparam int WIN_FULL = 40;
	localparam int WIN_HALF = 20;
	localparam int ZX_WAIT = 10;
	localparam int RMS_SHORT = 100;
	localparam int RMS_LONG = 200;
	always #2.5 sys_clk = ~sys_clk;
	emr_register_bank #(.FAST_FULL_CYCLES(WIN_FULL), .FAST_HALF_CYCLES(WIN_HALF),
		.ZX_DELAY_CYCLES(ZX_WAIT), .RMS_FAST_CYCLES(RMS_SHORT),
		.RMS_SLOW_CYCLES(RMS_LONG)) dut (.sys_clk, .rstn, .host_addr,
		.host_wdata, .host_wr, .host_rd, .host_rdata, .host_rvalid, .dsp_fast_rms, .dsp_i_wave,
		.dsp_v_wave, .dsp_wave_valid, .dsp_i_rms, .dsp_voltage_rms_result, .dsp_power, .dsp_phase,
		.dsp_energy_pulse, .dsp_int_temp, .dsp_ext_temp, .dsp_temp_valid, .fast_rms_control,
		.current_dc_offset_trim, .current_rms_offset_trim, .power_offset_trim,
		.no_load_threshold, .user_mode_select, .temperature_control, .ext_temp_gain_trim,
		.ext_temp_offset_trim, .zero_cross_output, .energy_pulse_output, .ext_temp_alarm);
	emr_host_model host (.sys_clk, .host_addr, .host_wdata, .host_wr, .host_rd, .host_rdata,
		.host_rvalid);
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [23:0] e);
		host.rd(a, rv);
		chk(rv, e);
	endtask
	task automatic unlock();
		host.wr(ADDR_WPROT, {16'h0000, WRITE_ENABLE_KEY});
	endtask
	task automatic wave(input logic [19:0] v);
		dsp_v_wave = v;
		dsp_wave_valid = 1'b1;
		cyc(1);
		dsp_wave_valid = 1'b0;
	endtask
	task automatic t_defaults();
		logic [7:0] a [13] = '{8'h10, 8'h11, 8'h13, 8'h15, 8'h17, 8'h18, 8'h19, 8'h1a,
			8'h1b, 8'h1c, 8'h1d, 8'h02, 8'h30};
		logic [15:0] e [13] = '{16'hffff, 0, 0, 0, 16'h000b, 0, 0, 0, 16'h07ff, 0, 0, 0, 0};
		for (int i = 0; i < 13; i++) begin
			rdc(a[i], {8'h00, e[i]});
		end
		chk(24'(fast_rms_control), 24'h00_ffff);
		chk(24'(no_load_threshold), 24'h00_000b);
		$display("defaults done");
	endtask
	task automatic t_protect();
		host.wr(ADDR_PWR_TRIM, 24'h00_0012);
		host.wr(ADDR_MODE, 24'h00_0100);
		rdc(ADDR_PWR_TRIM, 24'h00_0000);
		rdc(ADDR_MODE, 24'h00_0000);
		unlock();
		host.wr(ADDR_PWR_TRIM, 24'h00_0012);
		chk(24'(power_offset_trim), 24'h00_0012);
		host.wr(ADDR_WPROT, 24'h00_0054);
		host.wr(ADDR_PWR_TRIM, 24'h00_0034);
		rdc(ADDR_PWR_TRIM, 24'h00_0012);
		$display("protect done");
	endtask
	task automatic t_results();
		dsp_fast_rms = 24'h12_3456;
		dsp_i_wave = 20'h8_0001;
		dsp_i_rms = 24'h65_4321;
		dsp_voltage_rms_result = 24'h0a_bcde;
		dsp_power = 24'hfe_dcba;
		dsp_phase = 16'h1357;
		dsp_int_temp = 10'h2aa;
		dsp_ext_temp = 10'h155;
		dsp_temp_valid = 1'b1;
		wave(20'h1_2345);
		dsp_temp_valid = 1'b0;
		cyc(250);
		unlock();
		host.wr(ADDR_I_RMS, 24'h00_0000);
		host.wr(ADDR_FAST_RMS, 24'h00_0000);
		rdc(ADDR_FAST_RMS, dsp_fast_rms);
		rdc(ADDR_I_WAVE, {{4{dsp_i_wave[19]}}, dsp_i_wave});
		rdc(ADDR_V_WAVE, {{4{dsp_v_wave[19]}}, dsp_v_wave});
		rdc(ADDR_I_RMS, dsp_i_rms);
		rdc(ADDR_VOLTAGE_RMS_RESULT, dsp_voltage_rms_result);
		rdc(ADDR_POWER, dsp_power);
		rdc(ADDR_PHASE, {8'h00, dsp_phase});
		rdc(ADDR_INT_TEMP, {14'h0000, dsp_int_temp});
		rdc(ADDR_EXT_TEMP, {14'h0000, dsp_ext_temp});
		$display("results done");
	endtask
	task automatic t_pulse();
		rdc(ADDR_PULSE_CNT, 24'h00_0000);
		for (int i = 0; i < 3; i++) begin
			dsp_energy_pulse = 1'b1;
			cyc(1);
			dsp_energy_pulse = 1'b0;
			chk(24'(energy_pulse_output), 24'h00_0001);
			cyc(2);
		end
		host.wr(ADDR_PULSE_CNT, 24'h00_0040);
		rdc(ADDR_PULSE_CNT, 24'h00_0003);
		$display("pulse done");
	endtask
	task automatic t_alarm();
		for (int i = 0; i < 3; i++) begin
			host.wr(ADDR_TEMP_CTRL, 24'h00_0154 + 24'(i));
			cyc(3);
			chk(24'(ext_temp_alarm), 24'(dsp_ext_temp >= 10'h154 + 10'(i)));
		end
		$display("alarm done");
	endtask
	task automatic t_soft();
		host.wr(ADDR_DC_TRIM, 24'h00_0005);
		host.wr(ADDR_CREEP, 24'h00_0022);
		host.wr(ADDR_SOFT_RST, 24'h5a_5a5b);
		cyc(1);
		chk(24'(current_dc_offset_trim), 24'h00_0005);
		host.wr(ADDR_SOFT_RST, SOFT_RESET_KEY);
		cyc(1);
		chk(24'(current_dc_offset_trim), 24'h00_0000);
		chk(24'(no_load_threshold), 24'h00_000b);
		chk(24'(temperature_control), 24'h00_07ff);
		host.wr(ADDR_DC_TRIM, 24'h00_0009);
		rdc(ADDR_DC_TRIM, 24'h00_0000);
		$display("soft reset done");
	endtask
	task automatic t_zero_cross();
		wave(20'hf_fff0);
		cyc(20);
		wave(20'h0_0010);
		cyc(ZX_WAIT - 1);
		chk(24'(zero_cross_output), 24'h00_0000);
		cyc(1);
		chk(24'(zero_cross_output), 24'h00_0001);
		wave(20'hf_fff0);
		cyc(ZX_WAIT - 1);
		chk(24'(zero_cross_output), 24'h00_0001);
		cyc(1);
		chk(24'(zero_cross_output), 24'h00_0000);
		$display("zero cross done");
	endtask
	// Reads come every two cycles, so the gap between two seen updates is the period.
	task automatic gap(input logic [7:0] a, output int n);
		dsp_fast_rms = 24'h00_00a1;
		dsp_i_rms = 24'h00_00a1;
		rv = 24'h00_0000;
		while (rv !== 24'h00_00a1) begin
			host.rd(a, rv);
		end
		dsp_fast_rms = 24'h00_00b2;
		dsp_i_rms = 24'h00_00b2;
		n = 0;
		while (rv !== 24'h00_00b2) begin
			host.rd(a, rv);
			n = n + 2;
		end
	endtask
	task automatic t_refresh();
		int n;
		gap(ADDR_I_RMS, n);
		chk(24'(n), 24'(RMS_SHORT));
		gap(ADDR_FAST_RMS, n);
		chk(24'(n), 24'(WIN_HALF));
		unlock();
		host.wr(ADDR_MODE, 24'h00_0100);
		chk(24'(user_mode_select), 24'h00_0100);
		host.wr(ADDR_FAST_CTRL, 24'h00_7fff);
		chk(24'(fast_rms_control), 24'h00_7fff);
		gap(ADDR_I_RMS, n);
		chk(24'(n), 24'(RMS_LONG));
		gap(ADDR_FAST_RMS, n);
		chk(24'(n), 24'(WIN_FULL));
		host.wr(ADDR_RMS_TRIM, 24'h00_0021);
		host.wr(ADDR_TGAIN, 24'h00_0032);
		host.wr(ADDR_TOFFS, 24'h00_0043);
		chk(24'(current_rms_offset_trim), 24'h00_0021);
		chk(24'(ext_temp_gain_trim), 24'h00_0032);
		chk(24'(ext_temp_offset_trim), 24'h00_0043);
		rdc(ADDR_TGAIN, 24'h00_0032);
		$display("refresh done");
	endtask
	initial begin
		repeat (20) @(negedge sys_clk);
		rstn = 1'b1;
		cyc(2);
		t_defaults();
		t_protect();
		t_results();
		t_pulse();
		t_alarm();
		t_soft();
		t_zero_cross();
		t_refresh();
		tally_and_finish();
	end
endmodule
